// *** core/ee_wdog_pkg.sv ***
// Constants, types and command codes for the serial memory with watchdog supervisor.
// Assumes a 10 MHz system clock and a 1 ms internal time base built from it.
package ee_wdog_pkg;

    // Time base
    localparam int CLK_NS = 100;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYC_DEF = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int MS_W = 12;
    localparam int HOLD_MS = 200;
    localparam int WD_LONG_MS = 1400;
    localparam int WD_MID_MS = 600;
    localparam int WD_SHORT_MS = 200;
    localparam int WRITE_MS_DEF = 5;

    // Array geometry
    localparam int ADDR_W = 9;
    localparam int MEM_BYTES = 512;
    localparam logic [ADDR_W-1:0] PROT_QTR_BASE = 9'h180;
    localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 9'h100;

    // Opcodes; array opcodes carry the upper address bit at UPPER_ADDR_POS
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_RD_ARRAY = 8'h03;
    localparam logic [7:0] OP_WR_ARRAY = 8'h02;
    localparam logic [7:0] OP_ARRAY_MASK = 8'hf7;
    localparam int UPPER_ADDR_POS = 3;

    // Serial clock counts within one frame
    localparam logic [5:0] CNT_OPCODE = 6'h08;
    localparam logic [5:0] CNT_ADDR = 6'h10;
    localparam logic [5:0] CNT_DATA_FIRST = 6'h18;
    localparam logic [5:0] CNT_DATA_LAST = 6'h30;
    localparam logic [5:0] CNT_MAX = 6'h3f;
    localparam logic [2:0] BYTE_LAST = 3'h7;

    // Status field codes
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_QTR = 2'h1;
    localparam logic [1:0] PROT_HALF = 2'h2;
    localparam logic [1:0] WD_1400 = 2'h0;
    localparam logic [1:0] WD_600 = 2'h1;
    localparam logic [1:0] WD_200 = 2'h2;
    localparam logic [1:0] WD_OFF = 2'h3;
    localparam logic [1:0] ST_UNUSED = 2'h0;
    localparam logic [7:0] ST_BUSY_ALL = 8'hff;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
        logic supply_ok;
    } pins_t;

    localparam pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1, supply_ok: 1'b0};

    // Nonvolatile part of the status byte, bits 5..2
    typedef struct packed {
        logic [1:0] wd_period;
        logic [1:0] prot_range;
    } nv_cfg_t;

    localparam nv_cfg_t NV_CFG_RESET = '{wd_period: 2'h0, prot_range: 2'h0};

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_SET_LATCH,
        CMD_CLR_LATCH,
        CMD_RD_STATUS,
        CMD_WR_STATUS,
        CMD_RD_ARRAY,
        CMD_WR_ARRAY
    } cmd_t;

endpackage

// *** core/spi_eeprom_watchdog_supervisor.sv ***
// Serial 512-byte nonvolatile memory slave with write latch, range protection and watchdog supervisor.
// Assumes an SPI master on the pins, a supply detector level on supply_ok_i, and a 10 MHz clk_i.
`timescale 1ns/10ps

module spi_eeprom_watchdog_supervisor
    import ee_wdog_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC_DEF,
    parameter int WRITE_MS = WRITE_MS_DEF,
    parameter int PAGE_BYTES = 4,
    parameter int BUF_DEPTH = 2,
    parameter bit RST_LEVEL = 1'b0
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    input wire logic supply_ok_i,
    output logic so_o,
    output logic so_oe_o,
    output logic rst_o,
    output logic rst_oe_o
);

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int PW = $clog2(PAGE_BYTES);
    localparam int BW = $clog2(BUF_DEPTH);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Decode an opcode; only the status read is accepted while a write runs
    function automatic cmd_t decode_op(input logic [7:0] op, input logic busy);
        cmd_t c;
        c = CMD_NONE;
        if (op == OP_RD_STATUS) begin
            c = CMD_RD_STATUS;
        end else if (!busy) begin
            if (op == OP_SET_LATCH) c = CMD_SET_LATCH;
            else if (op == OP_CLR_LATCH) c = CMD_CLR_LATCH;
            else if (op == OP_WR_STATUS) c = CMD_WR_STATUS;
            else if ((op & OP_ARRAY_MASK) == OP_RD_ARRAY) c = CMD_RD_ARRAY;
            else if ((op & OP_ARRAY_MASK) == OP_WR_ARRAY) c = CMD_WR_ARRAY;
        end
        return c;
    endfunction

    // Protected ranges always end at the top of the array
    function automatic logic is_locked(input logic [1:0] range, input logic [ADDR_W-1:0] a);
        logic l;
        case (range)
            PROT_NONE: l = 1'b0;
            PROT_QTR: l = (a >= PROT_QTR_BASE);
            PROT_HALF: l = (a >= PROT_HALF_BASE);
            default: l = 1'b1;
        endcase
        return l;
    endfunction

    // Watchdog limit in milliseconds, last count before expiry
    function automatic logic [MS_W-1:0] wd_limit(input logic [1:0] period);
        logic [MS_W-1:0] n;
        case (period)
            WD_1400: n = MS_W'(WD_LONG_MS - 1);
            WD_600: n = MS_W'(WD_MID_MS - 1);
            default: n = MS_W'(WD_SHORT_MS - 1);
        endcase
        return n;
    endfunction

    pins_t pins_in;
    pins_t meta_q;
    pins_t sync_q;
    pins_t prev_q;
    logic sck_rise, sck_fall, cs_fall, cs_rise, sel, active, byte_done;
    logic [7:0] rx_byte;
    logic [TW-1:0] tick_cnt_q;
    logic tick;
    logic [MS_W-1:0] hold_q;
    logic [MS_W-1:0] wd_q;
    logic wd_on, wd_expire;
    logic armed_q;
    logic [5:0] bit_cnt_q;
    logic [7:0] shift_q;
    cmd_t cmd_q;
    cmd_t op_dec;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] page_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] dirty_q;
    nv_cfg_t st_new_q;
    nv_cfg_t cfg_q;
    logic wel_q, busy_q, wr_status_q;
    logic [MS_W-1:0] wr_cnt_q;
    logic start_arr, start_st, write_done, count_ok;
    logic [7:0] mem_q [MEM_BYTES];
    logic [7:0] status_byte;
    logic [7:0] fifo_q [BUF_DEPTH];
    logic [BW-1:0] wr_ptr_q, rd_ptr_q;
    logic [BW:0] fill_q;
    logic push, pop, fifo_full, fifo_empty;
    logic rd_phase;
    logic [7:0] out_sh_q, out_byte;
    logic [2:0] out_bits_q;

    // Two-stage synchroniser on every pin, then one more stage for edge finding
    assign pins_in = {cs_n_i, sck_i, si_i, wp_n_i, supply_ok_i};
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_q <= PINS_IDLE;
            sync_q <= PINS_IDLE;
            prev_q <= PINS_IDLE;
        end else begin
            meta_q <= pins_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign sck_rise = sync_q.sck & ~prev_q.sck;
    assign sck_fall = ~sync_q.sck & prev_q.sck;
    assign cs_fall = ~sync_q.cs_n & prev_q.cs_n;
    assign cs_rise = sync_q.cs_n & ~prev_q.cs_n;
    assign sel = ~sync_q.cs_n;
    assign active = sel & armed_q;
    assign rx_byte = {shift_q[6:0], sync_q.si};
    assign byte_done = sck_rise & active & (bit_cnt_q[2:0] == BYTE_LAST);
    // Status polls during a write must leave the pending page's upper address bit alone
    assign op_dec = decode_op(rx_byte, busy_q);

    // Free-running 1 ms tick, independent of the serial clock
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

    // Reset hold: reloaded while supply is low or on watchdog expiry
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !sync_q.supply_ok || wd_expire) begin
            hold_q <= MS_W'(HOLD_MS);
        end else if (tick && hold_q != '0) begin
            hold_q <= hold_q - 1'b1;
        end
    end

    // Watchdog runs only once the supervisor is out of reset hold
    assign wd_on = (cfg_q.wd_period != WD_OFF) & (hold_q == '0) & sync_q.supply_ok;
    assign wd_expire = wd_on & tick & (wd_q >= wd_limit(cfg_q.wd_period));
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || cs_fall || !wd_on || wd_expire) begin
            wd_q <= '0;
        end else if (tick) begin
            wd_q <= wd_q + 1'b1;
        end
    end

    // Open-drain reset output; level is fixed, enable carries the state
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rst_o <= RST_LEVEL;
            rst_oe_o <= 1'b1;
        end else begin
            rst_o <= RST_LEVEL;
            rst_oe_o <= ~sync_q.supply_ok | (hold_q != '0) | wd_expire;
        end
    end

    property p_rst_on_low_supply;
        !sync_q.supply_ok |=> rst_oe_o ##1 rst_oe_o;
    endproperty
    a_rst_on_low_supply: assert property (p_rst_on_low_supply)
        else $error("reset not driven while supply low");

    property p_wd_expiry_resets;
        wd_expire |=> rst_oe_o && hold_q == MS_W'(HOLD_MS);
    endproperty
    a_wd_expiry_resets: assert property (p_wd_expiry_resets)
        else $error("watchdog expiry did not start a reset hold");

    // Frames are ignored after a supply loss until chip select falls again
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !sync_q.supply_ok) begin
            armed_q <= 1'b0;
        end else if (cs_fall) begin
            armed_q <= 1'b1;
        end
    end

    // Frame decoder: bit count, instruction, address and page load
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bit_cnt_q <= '0;
            shift_q <= '0;
            cmd_q <= CMD_NONE;
            addr_q <= '0;
            dirty_q <= '0;
            st_new_q <= NV_CFG_RESET;
        end else if (!sel) begin
            bit_cnt_q <= '0;
            cmd_q <= CMD_NONE;
        end else if (sck_rise && armed_q) begin
            shift_q <= rx_byte;
            if (bit_cnt_q != CNT_MAX) begin
                bit_cnt_q <= bit_cnt_q + 1'b1;
            end
            if (byte_done) begin
                case (bit_cnt_q[5:3])
                    3'h0: begin
                        cmd_q <= op_dec;
                        if (op_dec == CMD_RD_ARRAY || op_dec == CMD_WR_ARRAY) begin
                            addr_q[ADDR_W-1] <= rx_byte[UPPER_ADDR_POS];
                        end
                        if (op_dec == CMD_WR_ARRAY) begin
                            dirty_q <= '0;
                        end
                    end
                    3'h1: begin
                        if (cmd_q == CMD_RD_ARRAY || cmd_q == CMD_WR_ARRAY) begin
                            addr_q[ADDR_W-2:0] <= rx_byte;
                        end
                        if (cmd_q == CMD_WR_STATUS) begin
                            st_new_q <= rx_byte[5:2];
                        end
                    end
                    default: begin
                        if (cmd_q == CMD_WR_ARRAY) begin
                            page_q[addr_q[PW-1:0]] <= rx_byte;
                            dirty_q[addr_q[PW-1:0]] <= 1'b1;
                            addr_q[PW-1:0] <= addr_q[PW-1:0] + 1'b1;
                        end
                    end
                endcase
            end
        end else if (push) begin
            addr_q <= addr_q + 1'b1;
        end
    end

    property p_capture_on_rise;
        $changed(shift_q) |-> $past(sck_rise) && $past(armed_q);
    endproperty
    a_capture_on_rise: assert property (p_capture_on_rise)
        else $error("input shifted without a rising serial clock");

    // Write start on chip select rise at a legal clock count
    assign count_ok = (bit_cnt_q[2:0] == 3'h0) && (bit_cnt_q >= CNT_DATA_FIRST) && (bit_cnt_q <= CNT_DATA_LAST);
    assign start_arr = cs_rise & armed_q & (cmd_q == CMD_WR_ARRAY) & count_ok & wel_q & sync_q.wp_n;
    assign start_st = cs_rise & armed_q & (cmd_q == CMD_WR_STATUS) & (bit_cnt_q == CNT_ADDR) & wel_q & sync_q.wp_n;
    assign write_done = busy_q & tick & (wr_cnt_q == MS_W'(WRITE_MS - 1));

    // Internal write cycle; protect changes cannot stop it once started
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            busy_q <= 1'b0;
            wr_status_q <= 1'b0;
            wr_cnt_q <= '0;
        end else if (start_arr || start_st) begin
            busy_q <= 1'b1;
            wr_status_q <= start_st;
            wr_cnt_q <= '0;
        end else if (write_done) begin
            busy_q <= 1'b0;
        end else if (busy_q && tick) begin
            wr_cnt_q <= wr_cnt_q + 1'b1;
        end
    end

    // Nonvolatile status pair; survives supply loss, only a full reset clears it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_q <= NV_CFG_RESET;
        end else if (write_done && wr_status_q) begin
            cfg_q <= st_new_q;
        end
    end

    // Array commit of loaded page bytes outside the locked range
    always_ff @(posedge clk_i) begin
        if (write_done && !wr_status_q) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (dirty_q[i] && !is_locked(cfg_q.prot_range, {addr_q[ADDR_W-1:PW], PW'(i)})) begin
                    mem_q[{addr_q[ADDR_W-1:PW], PW'(i)}] <= page_q[i];
                end
            end
        end
    end

    // Write latch: cleared on supply loss, protect low and write completion
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !sync_q.supply_ok) begin
            wel_q <= 1'b0;
        end else if (!sync_q.wp_n || write_done) begin
            wel_q <= 1'b0;
        end else if (cs_rise && armed_q && bit_cnt_q == CNT_OPCODE) begin
            if (cmd_q == CMD_SET_LATCH) wel_q <= 1'b1;
            else if (cmd_q == CMD_CLR_LATCH) wel_q <= 1'b0;
        end
    end

    property p_wp_clears_latch;
        !sync_q.wp_n |=> !wel_q;
    endproperty
    a_wp_clears_latch: assert property (p_wp_clears_latch)
        else $error("write latch still set while write protect low");

    property p_write_needs_latch;
        $rose(busy_q) |-> $past(wel_q) && $past(sync_q.wp_n);
    endproperty
    a_write_needs_latch: assert property (p_write_needs_latch)
        else $error("write started without latch or with protect low");

    property p_write_clock_count;
        $rose(busy_q) && !wr_status_q |-> $past(count_ok) && $past(cs_rise);
    endproperty
    a_write_clock_count: assert property (p_write_clock_count)
        else $error("array write started at an illegal clock count");

    // Live status byte; all ones while a write runs
    assign status_byte = busy_q ? ST_BUSY_ALL : {ST_UNUSED, cfg_q, wel_q, 1'b0};

    property p_busy_status;
        sck_fall && rd_phase && out_bits_q == '0 && cmd_q == CMD_RD_STATUS && busy_q
            |=> so_o && out_sh_q == {ST_BUSY_ALL[6:0], 1'b0};
    endproperty
    a_busy_status: assert property (p_busy_status)
        else $error("status not all ones during a write");

    // Two-entry read buffer; the prefetch stalls when the shifter falls behind
    assign fifo_full = (fill_q == (BW + 1)'(BUF_DEPTH));
    assign fifo_empty = (fill_q == '0);
    assign push = active & (cmd_q == CMD_RD_ARRAY) & (bit_cnt_q >= CNT_ADDR) & ~fifo_full & ~sck_rise;
    assign rd_phase = active & (((cmd_q == CMD_RD_STATUS) & (bit_cnt_q >= CNT_OPCODE))
        | ((cmd_q == CMD_RD_ARRAY) & (bit_cnt_q >= CNT_ADDR)));
    assign pop = sck_fall & rd_phase & (out_bits_q == '0) & (cmd_q == CMD_RD_ARRAY) & ~fifo_empty;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !sel) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            fill_q <= '0;
        end else begin
            if (push) begin
                fifo_q[wr_ptr_q] <= mem_q[addr_q];
                wr_ptr_q <= (wr_ptr_q == BW'(BUF_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == BW'(BUF_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            fill_q <= fill_q + (BW + 1)'(push) - (BW + 1)'(pop);
        end
    end

    // Serial output: new bit only after a falling edge, most significant first
    assign out_byte = (cmd_q == CMD_RD_STATUS) ? status_byte : (fifo_empty ? 8'h00 : fifo_q[rd_ptr_q]);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
            out_sh_q <= '0;
            out_bits_q <= '0;
        end else begin
            so_oe_o <= rd_phase;
            if (!sel) begin
                out_bits_q <= '0;
            end else if (sck_fall && rd_phase) begin
                if (out_bits_q == '0) begin
                    so_o <= out_byte[7];
                    out_sh_q <= {out_byte[6:0], 1'b0};
                    out_bits_q <= BYTE_LAST;
                end else begin
                    so_o <= out_sh_q[7];
                    out_sh_q <= {out_sh_q[6:0], 1'b0};
                    out_bits_q <= out_bits_q - 1'b1;
                end
            end
        end
    end

    property p_so_after_fall;
        $changed(so_o) |-> $past(sck_fall) && $past(rd_phase);
    endproperty
    a_so_after_fall: assert property (p_so_after_fall)
        else $error("serial output changed without a falling clock");

    property p_deselect_tristate;
        sync_q.cs_n |=> !so_oe_o;
    endproperty
    a_deselect_tristate: assert property (p_deselect_tristate)
        else $error("output enabled while deselected");

endmodule // spi_eeprom_watchdog_supervisor

// *** bench/spi_master_model.sv ***
// SPI master model for the serial memory pins.
// Assumes the memory samples these pins with clk_i; link clock period 800 ns.
`timescale 1ns/10ps
module spi_master_model (
    input wire logic clk_i,
    input wire logic so_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end

    // Pins move 1 ns after a clock edge, never on it
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // One frame, most significant bit first; clock rests low between frames
    task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
        rx = '0;
        tick(1);
        cs_n_o = 1'b0; // Falling select arms the device
        for (int i = nbits - 1; i >= 0; i--) begin
            si_o = tx[i];
            tick(4);
            sck_o = 1'b1;
            tick(4);
            rx = {rx[62:0], so_i}; // Late in the high phase, output still holds
            sck_o = 1'b0;
        end
        tick(4);
        cs_n_o = 1'b1;
        si_o = ~si_o; // Released line never keeps a stale bit
        tick(8);
    endtask
endmodule // spi_master_model

// *** bench/test_spi_eeprom_watchdog_supervisor.sv ***
// Self-checking bench for the serial memory with watchdog supervisor.
// Assumes the SPI master model and a 10 MHz clock; one ms is shortened to 10 clocks.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
$display("BAD %s exp %h got %h", nm, ex, got); end end
module test_spi_eeprom_watchdog_supervisor;
    import ee_wdog_pkg::*;
    // Short time base: 200 ms becomes about 2000 cycles
    localparam int TK = 10;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wp_n_i = 1'b1;
    logic supply_ok_i = 1'b1;
    logic cs_n, sck, si, so_o, so_oe_o, rst_o, rst_oe_o;
    logic [63:0] rx;
    int failures = 0;
    int checks_done = 0;
    int n;

    initial forever #50 clk_i = ~clk_i;

    spi_eeprom_watchdog_supervisor #(.TICK_CYCLES(TK), .WRITE_MS(30)) spi_eeprom_watchdog_supervisor_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .wp_n_i(wp_n_i),
        .supply_ok_i(supply_ok_i), .so_o(so_o), .so_oe_o(so_oe_o), .rst_o(rst_o), .rst_oe_o(rst_oe_o));
    // A disabled output shows the inverse of its last bit, so a late enable corrupts the data
    spi_master_model spi_master_model_inst (.clk_i(clk_i), .so_i(so_oe_o ? so_o : ~so_o), .cs_n_o(cs_n),
        .sck_o(sck), .si_o(si));

    task automatic xf(input logic [63:0] tx, input int nb);
        spi_master_model_inst.frame(tx, nb, rx);
    endtask
    task automatic st();
        xf({48'h0, OP_RD_STATUS, 8'h00}, 16);
    endtask
    task automatic set_write_latch_cmd();
        xf({56'h0, OP_SET_LATCH}, 8);
    endtask
    // Bounded poll while the internal write runs
    task automatic wait_idle();
        for (int k = 0; k < 12; k++) begin
            st();
            if (rx[7:0] !== ST_BUSY_ALL) break;
        end
    endtask
    // Count cycles while reset is driven, bounded
    task automatic hold(input int lo, input int hi);
        n = 0;
        while (rst_oe_o === 1'b1 && n < 5000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        `CHK("hold", 1'b1, (n >= lo && n <= hi))
    endtask
    function automatic logic [7:0] aop(input logic [7:0] b, input logic [8:0] a);
        return b | {4'h0, a[8], 3'h0};
    endfunction
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs roughly 17000 cycles
    initial begin
        #(60000 * 100);
        failures++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        `CHK("rst_oe", 1'b1, rst_oe_o)
        hold(1980, 2030);
        $display("test hold done");
        st();
        `CHK("status", 8'h00, rx[7:0])
        set_write_latch_cmd();
        st();
        `CHK("latch", 8'h02, rx[7:0])
        xf({56'h0, OP_CLR_LATCH}, 8);
        st();
        `CHK("unlatch", 8'h00, rx[7:0])
        `CHK("so_oe", 1'b0, so_oe_o)
        $display("test latch done");
        // Page wrap: 1fe,1ff then back to 1fc,1fd
        set_write_latch_cmd();
        xf({16'h0, aop(OP_WR_ARRAY, 9'h1fe), 8'hfe, 32'haabbccdd}, 48);
        st();
        `CHK("busy", ST_BUSY_ALL, rx[7:0])
        wait_idle();
        `CHK("done", 8'h00, rx[7:0])
        set_write_latch_cmd();
        xf({40'h0, OP_WR_ARRAY, 8'h00, 8'h11}, 24);
        wait_idle();
        xf({8'h0, aop(OP_RD_ARRAY, 9'h1fc), 8'hfc, 40'h0}, 56);
        `CHK("array", 40'hccddaabb11, rx[39:0])
        $display("test array done");
        // Twenty clocks is no legal write length
        set_write_latch_cmd();
        xf({44'h0, OP_WR_ARRAY, 8'h00, 4'h2}, 20);
        st();
        `CHK("short", 8'h02, rx[7:0])
        wp_n_i = 1'b0;
        xf({48'h0, OP_WR_STATUS, 8'h3c}, 16);
        st();
        `CHK("wp", 8'h00, rx[7:0])
        wp_n_i = 1'b1;
        set_write_latch_cmd();
        xf({48'h0, OP_WR_STATUS, 8'h04}, 16);
        wait_idle();
        `CHK("prot", 8'h04, rx[7:0])
        set_write_latch_cmd();
        xf({40'h0, aop(OP_WR_ARRAY, 9'h1fc), 8'hfc, 8'h55}, 24);
        wait_idle();
        xf({32'h0, aop(OP_RD_ARRAY, 9'h1fc), 8'hfc, 16'h0}, 32);
        `CHK("locked", 16'hccdd, rx[15:0])
        $display("test guard done");
        // 200 ms period, select left high after the frame
        set_write_latch_cmd();
        xf({48'h0, OP_WR_STATUS, 8'h24}, 16);
        n = 0;
        while (rst_oe_o !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        `CHK("wdog", 1'b1, (n > 1700 && n < 2010))
        hold(1980, 2030);
        set_write_latch_cmd();
        xf({48'h0, OP_WR_STATUS, 8'h30}, 16);
        wait_idle();
        `CHK("wd_off", 8'h30, rx[7:0])
        repeat (3000) @(posedge clk_i);
        #1;
        `CHK("no_wdog", 1'b0, rst_oe_o)
        $display("test wdog done");
        supply_ok_i = 1'b0;
        repeat (5) @(posedge clk_i);
        #1;
        `CHK("pf", 1'b1, rst_oe_o)
        `CHK("rst_lvl", 1'b0, rst_o)
        supply_ok_i = 1'b1;
        hold(1980, 2030);
        st();
        `CHK("keep", 8'h30, rx[7:0])
        $display("test supply done");
        close_out();
    end
endmodule // test_spi_eeprom_watchdog_supervisor
